// [pkg/config_word_pkg.sv]
// Constants, field layout and carrier types for the configuration word decoder.
// Assumes the includer runs one clock and an asynchronous active-low reset.
package config_word_pkg;

    localparam int          WORD_W           = 14;
    localparam int          ADDR_W           = 16;
    localparam int          FLASH_ADDR_W     = 14;

    // Configuration space addresses
    localparam logic [15:0] CFG_ONE_ADDR     = 16'h8007;
    localparam logic [15:0] CFG_TWO_ADDR     = 16'h8008;
    localparam logic [15:0] CAL_ONE_ADDR     = 16'h8009;
    localparam logic [15:0] CAL_TWO_ADDR     = 16'h800a;

    // Blank cells read as ones; programming only clears bits
    localparam logic [13:0] ERASED_WORD      = 14'h3fff;

    // First word fields
    localparam int          FAILSAFE_BIT     = 13;
    localparam int          SWITCHOVER_BIT   = 12;
    localparam int          CLKOUT_N_BIT     = 11;
    localparam int          BOR_MODE_LSB     = 9;
    localparam int          DATA_PROT_N_BIT  = 8;
    localparam int          PROG_PROT_N_BIT  = 7;
    localparam int          RESET_PIN_BIT    = 6;
    localparam int          PWRT_N_BIT       = 5;
    localparam int          WDT_MODE_LSB     = 3;
    localparam int          OSC_LSB          = 0;

    // Second word fields
    localparam int          LVP_BIT          = 13;
    localparam int          DEBUG_N_BIT      = 12;
    localparam int          ULP_BOR_N_BIT    = 11;
    localparam int          BOR_LEVEL_BIT    = 10;
    localparam int          STACK_RESET_BIT  = 9;
    localparam int          MULT_BIT         = 8;
    localparam int          VCAP_LSB         = 4;
    localparam int          SELF_WRITE_LSB   = 0;

    // Positions that read back as one, per variant
    localparam logic [13:0] ONE_ONES_REDUCED = 14'h3104;
    localparam logic [13:0] TWO_ONES_MAIN    = 14'h08cc;
    localparam logic [13:0] TWO_ONES_WIDE    = 14'h08ec;
    localparam logic [13:0] TWO_ONES_REDUCED = 14'h01fc;

    // Top of the boot block protected by self-write field 10
    localparam logic [13:0] BOOT_BLOCK_TOP   = 14'h01ff;

    typedef enum logic [1:0] {VARIANT_MAIN, VARIANT_WIDE_PIN, VARIANT_REDUCED} variant_t;
    typedef enum logic [1:0] {BOR_DISABLED, BOR_SOFTWARE, BOR_RUN_ONLY, BOR_ALWAYS} brownout_mode_t;
    typedef enum logic [1:0] {WDT_DISABLED, WDT_SOFTWARE, WDT_RUN_ONLY, WDT_ALWAYS} watchdog_mode_t;
    typedef enum logic [2:0] {
        low_power_crystal, crystal_osc, high_speed_crystal, external_rc_osc,
        internal_osc, ext_clock_low, ext_clock_med, ext_clock_high
    } osc_select_t;
    typedef enum logic [2:0] {CAP_ON_RA0, CAP_ON_RA5, CAP_ON_RA6, CAP_OFF, CAP_ON_RF0} regulator_cap_t;

    typedef struct packed {
        logic           failsafe_monitor_en;
        logic           clock_switchover_en;
        logic           clock_output_en;
        brownout_mode_t brownout_mode;
        logic           data_readout_block;
        logic           program_readout_block;
        logic           reset_pin_en;
        logic           powerup_timer_en;
        watchdog_mode_t watchdog_mode;
        osc_select_t    osc_select;
        logic           low_volt_prog_en;
        logic           debugger_en;
        logic           ultra_low_brownout_en;
        logic           brownout_low_level;
        logic           stack_fault_reset_en;
        logic           multiplier_en;
        regulator_cap_t regulator_cap_select;
        logic [1:0]     self_write_protect;
    } settings_t;

    typedef struct packed {
        logic [13:0] word_one;
        logic [13:0] word_two;
        settings_t   settings;
        logic        load_pending;
        logic        prog_mode_seen;
        logic [13:0] rdata;
        logic        rvalid;
        logic        program_erase;
        logic        data_erase;
        logic        lvp_refused;
        logic        self_write_blocked;
        logic        self_write_granted;
    } decoder_state_t;

endpackage

// [logic/clock_select_decode.sv]
// Maps the oscillator field onto the clock source selection.
// Assumes a stable field; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module clock_select_decode #(
    parameter bit REDUCED = 1'b0
) (
    // Field
    input  wire logic [2:0]                  osc_field_in,
    // Selection
    output var config_word_pkg::osc_select_t osc_select_out
);
    import config_word_pkg::*;

    // Reduced parts hold the top bit at one, so the two-bit field lands on
    // the same external-clock and internal codes as the full field.
    always_comb begin
        if (REDUCED) begin
            osc_select_out = osc_select_t'({1'b1, osc_field_in[1:0]});
        end else begin
            osc_select_out = osc_select_t'(osc_field_in);
        end
    end
endmodule
`default_nettype wire

// [logic/self_write_guard.sv]
// Decides whether a self-write address falls in the protected flash range.
// Assumes flash size is a power of two of at least 1K words.
`timescale 1ns/1ps
`default_nettype none
module self_write_guard #(
    parameter int MEM_WORDS = 4096
) (
    // Request
    input  wire logic [1:0]  protect_field_in,
    input  wire logic [13:0] addr_in,
    // Verdict
    output logic             blocked_out
);
    import config_word_pkg::*;

    localparam logic [13:0] HALF_TOP = 14'(MEM_WORDS / 2 - 1);
    localparam logic [13:0] FULL_TOP = 14'(MEM_WORDS - 1);

    always_comb begin
        case (protect_field_in)
            2'b11:   blocked_out = 1'b0;
            2'b10:   blocked_out = (addr_in <= BOOT_BLOCK_TOP);
            2'b01:   blocked_out = (addr_in <= HALF_TOP);
            default: blocked_out = (addr_in <= FULL_TOP);
        endcase
    end
endmodule
`default_nettype wire

// [logic/config_word_decoder.sv]
// Configuration word store and decoder: holds the two configuration words,
// serves the calibration words and drives static control settings.
// Assumes the serial programming front end has already turned link traffic
// into word reads, writes and erase strobes while programming mode is held.
//
// Overview of operation
// - First configuration word at 8007h, second at 8008h.
// - Calibration words at 8009h and 800Ah survive every erase.
// - First word bit 13 enables clock monitor; bit 12 enables switchover.
// - First word bit 11 low routes clock output to its pin.
// - Brown-out field bits 10-9: always, run only, software, disabled.
// - First word bit 8 low blocks external data memory readout.
// - First word bit 7 low blocks external program memory readout.
// - Lifting program protection erases program memory; data likewise erases EEPROM.
// - Reset pin bit 6 ignored under low-voltage programming, else selects pin role.
// - Bit 5 low enables power-up timer; brown-out never implies it.
// - Watchdog field bits 4-3: always, run only, software, disabled.
// - Oscillator field bits 2-0 selects one of eight clock sources.
// - Reduced variant: bit 2 reads one, two-bit field picks clock.
// - Second word bit 13 enables low-voltage entry; cannot clear it that way.
// - Second word bit 12 low enables debugger and claims programming pins.
// - Second word bit 10 selects 1.9V when one, 2.7V when zero.
// - Second word bit 9 one makes stack faults cause reset.
// - Second word bit 8 enables the times-four clock multiplier.
// - Regulator capacitor field places pin or disables; single-bit variant uses RF0.
// - Unimplemented second word positions read back as one.
// - 4K part: self-write field protects nothing, 1FFh, 7FFh or FFFh.
// - 8K part: self-write field protects nothing, 1FFh, FFFh or 1FFFh.
// - Words reachable only through serial programming mode, LSb first.
`timescale 1ns/1ps
`default_nettype none
module config_word_decoder #(
    parameter config_word_pkg::variant_t VARIANT      = config_word_pkg::VARIANT_MAIN,
    parameter int                        MEM_WORDS    = 4096,
    // Factory calibration contents; values arbitrary
    parameter logic [13:0]               CAL_ONE_INIT = 14'h1234,
    parameter logic [13:0]               CAL_TWO_INIT = 14'h0abc
) (
    // Clock and reset
    input  wire logic                        ref_clk_in,
    input  wire logic                        rst_n_in,
    // Programming port
    input  wire logic                        prog_mode_in,
    input  wire logic                        lvp_entry_in,
    input  wire logic [15:0]                 prog_addr_in,
    input  wire logic                        prog_write_in,
    input  wire logic [13:0]                 prog_wdata_in,
    input  wire logic                        prog_read_in,
    input  wire logic                        erase_program_in,
    input  wire logic                        erase_data_in,
    output logic [13:0]                      prog_rdata_out,
    output logic                             prog_rvalid_out,
    output logic                             lvp_refused_out,
    // Erase orders to the memory arrays
    output logic                             program_erase_out,
    output logic                             data_erase_out,
    // Self-write check
    input  wire logic                        self_write_req_in,
    input  wire logic [13:0]                 self_write_addr_in,
    output logic                             self_write_blocked_out,
    output logic                             self_write_granted_out,
    // Decoded static settings
    output config_word_pkg::settings_t       settings_out
);
    import config_word_pkg::*;

    localparam bit REDUCED = (VARIANT == VARIANT_REDUCED);

    decoder_state_t state_reg;
    decoder_state_t state_next;

    logic [13:0]    one_view;
    logic [13:0]    two_view;
    osc_select_t    osc_decoded;
    logic           guard_blocked;
    logic           in_prog;

    // Applies the read-as-one positions of the chosen variant
    function automatic logic [13:0] view_one(input logic [13:0] stored);
        view_one = REDUCED ? (stored | ONE_ONES_REDUCED) : stored;
    endfunction

    function automatic logic [13:0] view_two(input logic [13:0] stored);
        if (VARIANT == VARIANT_REDUCED) begin
            view_two = stored | TWO_ONES_REDUCED;
        end else if (VARIANT == VARIANT_WIDE_PIN) begin
            view_two = stored | TWO_ONES_WIDE;
        end else begin
            view_two = stored | TWO_ONES_MAIN;
        end
    endfunction

    function automatic regulator_cap_t cap_decode(input logic [13:0] w2);
        if (VARIANT == VARIANT_REDUCED) begin
            cap_decode = CAP_OFF;
        end else if (VARIANT == VARIANT_WIDE_PIN) begin
            cap_decode = w2[VCAP_LSB] ? CAP_OFF : CAP_ON_RF0;
        end else begin
            cap_decode = regulator_cap_t'({1'b0, w2[VCAP_LSB +: 2]});
        end
    endfunction

    function automatic settings_t decode(input logic [13:0] w1,
                                         input logic [13:0] w2,
                                         input osc_select_t osc);
        settings_t s;
        s.failsafe_monitor_en   = w1[FAILSAFE_BIT];
        s.clock_switchover_en   = w1[SWITCHOVER_BIT];
        s.clock_output_en       = ~w1[CLKOUT_N_BIT];
        s.brownout_mode         = brownout_mode_t'(w1[BOR_MODE_LSB +: 2]);
        s.data_readout_block    = ~w1[DATA_PROT_N_BIT];
        s.program_readout_block = ~w1[PROG_PROT_N_BIT];
        // Low-voltage entry keeps the reset pin live whatever bit 6 says
        s.reset_pin_en          = w2[LVP_BIT] | w1[RESET_PIN_BIT];
        // Power-up timer follows only its own bit, never the brown-out mode
        s.powerup_timer_en      = ~w1[PWRT_N_BIT];
        s.watchdog_mode         = watchdog_mode_t'(w1[WDT_MODE_LSB +: 2]);
        s.osc_select            = osc;
        s.low_volt_prog_en      = w2[LVP_BIT];
        s.debugger_en           = ~w2[DEBUG_N_BIT];
        s.ultra_low_brownout_en = REDUCED ? ~w2[ULP_BOR_N_BIT] : 1'b0;
        s.brownout_low_level    = w2[BOR_LEVEL_BIT];
        s.stack_fault_reset_en  = w2[STACK_RESET_BIT];
        s.multiplier_en         = w2[MULT_BIT];
        s.regulator_cap_select  = cap_decode(w2);
        s.self_write_protect    = w2[SELF_WRITE_LSB +: 2];
        decode = s;
    endfunction

    assign one_view = view_one(state_reg.word_one);
    assign two_view = view_two(state_reg.word_two);
    assign in_prog  = prog_mode_in;

    clock_select_decode #(
        .REDUCED        (REDUCED)
    ) u_clock_select (
        .osc_field_in   (one_view[OSC_LSB +: 3]),
        .osc_select_out (osc_decoded)
    );

    // Checks against the live settings, not the stored words, so a freshly
    // programmed field takes effect only once it has been latched.
    self_write_guard #(
        .MEM_WORDS        (MEM_WORDS)
    ) u_self_write_guard (
        .protect_field_in (state_reg.settings.self_write_protect),
        .addr_in          (self_write_addr_in),
        .blocked_out      (guard_blocked)
    );

    always_comb begin
        logic [13:0] wdata;
        wdata = prog_wdata_in;
        state_next = state_reg;

        // One-cycle strobes fall back every cycle
        state_next.rvalid             = 1'b0;
        state_next.program_erase      = 1'b0;
        state_next.data_erase         = 1'b0;
        state_next.lvp_refused        = 1'b0;
        state_next.self_write_blocked = 1'b0;
        state_next.self_write_granted = 1'b0;
        state_next.prog_mode_seen     = in_prog;

        // Latch after reset release and again when programming mode ends
        if (state_reg.load_pending || (state_reg.prog_mode_seen && !in_prog)) begin
            state_next.settings     = decode(one_view, two_view, osc_decoded);
            state_next.load_pending = 1'b0;
        end

        // Word access only inside programming mode
        if (in_prog) begin
            if (erase_program_in) begin
                // Config words blank with the array, except that a cleared LVP bit stays cleared under low-voltage entry; calibration is left alone
                state_next.word_one      = ERASED_WORD;
                state_next.word_two      = ERASED_WORD;
                state_next.program_erase = 1'b1;
                state_next.data_erase    = ~state_reg.word_one[DATA_PROT_N_BIT];
                if (lvp_entry_in && !state_reg.word_two[LVP_BIT]) begin
                    state_next.word_two[LVP_BIT] = 1'b0;
                end
            end else if (erase_data_in) begin
                state_next.data_erase = 1'b1;
            end else if (prog_write_in) begin
                if (lvp_entry_in && !wdata[LVP_BIT] && prog_addr_in == CFG_TWO_ADDR) begin
                    wdata[LVP_BIT]          = 1'b1;
                    state_next.lvp_refused  = 1'b1;
                end
                // Programming can only clear bits; writes elsewhere are ignored
                if (prog_addr_in == CFG_ONE_ADDR) begin
                    state_next.word_one = state_reg.word_one & wdata;
                end else if (prog_addr_in == CFG_TWO_ADDR) begin
                    state_next.word_two = state_reg.word_two & wdata;
                end
            end else if (prog_read_in) begin
                state_next.rvalid = 1'b1;
                if (prog_addr_in == CFG_ONE_ADDR) begin
                    state_next.rdata = one_view;
                end else if (prog_addr_in == CFG_TWO_ADDR) begin
                    state_next.rdata = two_view;
                end else if (prog_addr_in == CAL_ONE_ADDR) begin
                    state_next.rdata = CAL_ONE_INIT;
                end else if (prog_addr_in == CAL_TWO_ADDR) begin
                    state_next.rdata = CAL_TWO_INIT;
                end else begin
                    state_next.rdata = '0;
                end
            end
        end

        // Self-writes are judged only outside programming mode
        if (self_write_req_in && !in_prog) begin
            state_next.self_write_blocked = guard_blocked;
            state_next.self_write_granted = ~guard_blocked;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg                    <= '0;
            state_reg.word_one           <= ERASED_WORD;
            state_reg.word_two           <= ERASED_WORD;
            state_reg.load_pending       <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prog_rdata_out         = state_reg.rdata;
    assign prog_rvalid_out        = state_reg.rvalid;
    assign lvp_refused_out        = state_reg.lvp_refused;
    assign program_erase_out      = state_reg.program_erase;
    assign data_erase_out         = state_reg.data_erase;
    assign self_write_blocked_out = state_reg.self_write_blocked;
    assign self_write_granted_out = state_reg.self_write_granted;
    assign settings_out           = state_reg.settings;

endmodule
`default_nettype wire

// [testbench/config_word_decoder_asserts.sv]
// Port assertions for the configuration word decoder.
// Assumes one clock, active-low async reset, and the default main variant.
`timescale 1ns/1ps
`default_nettype none
module config_word_decoder_asserts
    import config_word_pkg::*;
#(
    parameter logic [13:0] CAL_ONE_INIT = 14'h0000,
    parameter logic [13:0] CAL_TWO_INIT = 14'h0000
) (
    // Clock and reset
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    // Programming port
    input wire logic        prog_mode_in,
    input wire logic        lvp_entry_in,
    input wire logic [15:0] prog_addr_in,
    input wire logic        prog_write_in,
    input wire logic [13:0] prog_wdata_in,
    input wire logic        prog_read_in,
    input wire logic        erase_program_in,
    input wire logic        erase_data_in,
    input wire logic [13:0] prog_rdata_out,
    input wire logic        prog_rvalid_out,
    input wire logic        lvp_refused_out,
    input wire logic        program_erase_out,
    input wire logic        data_erase_out,
    // Self-write and settings
    input wire logic        self_write_req_in,
    input wire logic [13:0] self_write_addr_in,
    input wire logic        self_write_blocked_out,
    input wire logic        self_write_granted_out,
    input wire settings_t   settings_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic armed_reg;
    logic settled_reg;
    wire  no_erase = !erase_program_in && !erase_data_in;
    wire  rd_ok    = prog_mode_in && prog_read_in && no_erase && !prog_write_in;
    wire  sw_ok    = self_write_req_in && !prog_mode_in;
    // Skip the load at reset release
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            {armed_reg, settled_reg} <= 2'b00;
        else
            {armed_reg, settled_reg} <= {1'b1, armed_reg};
    end
    read_answer_a: assert property (rd_ok |=> prog_rvalid_out)
        else $error("read not answered");
    idle_port_a: assert property (!prog_mode_in |=> !prog_rvalid_out && !program_erase_out)
        else $error("request taken outside programming mode");
    cal_read_a: assert property (rd_ok && prog_addr_in == CAL_TWO_ADDR |=> prog_rdata_out == CAL_TWO_INIT)
        else $error("calibration word changed");
    unused_ones_a: assert property (rd_ok && prog_addr_in == CFG_TWO_ADDR |=> &(prog_rdata_out | ~TWO_ONES_MAIN))
        else $error("unused bit read as zero");
    erase_order_a: assert property (prog_mode_in && erase_program_in |=> program_erase_out)
        else $error("program erase not ordered");
    low_volt_keep_a: assert property (prog_mode_in && lvp_entry_in && prog_write_in && no_erase
        && prog_addr_in == CFG_TWO_ADDR && !prog_wdata_in[LVP_BIT] |=> lvp_refused_out)
        else $error("low voltage bit clear not refused");
    settings_hold_a: assert property (settled_reg && !$stable(settings_out)
        |-> !$past(prog_mode_in) && $past(prog_mode_in, 2))
        else $error("settings moved outside relatch");
    one_verdict_a: assert property (sw_ok |=> self_write_blocked_out ^ self_write_granted_out)
        else $error("self write verdict not unique");
    open_range_a: assert property (sw_ok && settings_out.self_write_protect == 2'b11 |=> self_write_granted_out)
        else $error("self write blocked with protection off");
    full_range_a: assert property (sw_ok && settings_out.self_write_protect == 2'b00
        && self_write_addr_in <= 14'h0fff |=> self_write_blocked_out)
        else $error("self write granted in full protection");
endmodule
bind config_word_decoder config_word_decoder_asserts #(
    .CAL_ONE_INIT(CAL_ONE_INIT), .CAL_TWO_INIT(CAL_TWO_INIT)) u_asserts (.*);
`default_nettype wire

// [testbench/prog_model.sv]
// Programmer model: issues word requests on the decoder programming port.
// Assumes the bench calls its tasks; answers packed {rvalid,refused,perase,derase,rdata}.
`timescale 1ns/1ps
`default_nettype none
module prog_model (
    // Clock and answers
    input  wire logic        clk_in,
    input  wire logic [17:0] ans_in,
    // Requests
    output logic             mode_out,
    output logic             entry_out,
    output logic [15:0]      addr_out,
    output logic             write_out,
    output logic [13:0]      wdata_out,
    output logic             read_out,
    output logic             erase_prog_out,
    output logic             erase_data_out
);
    initial begin
        {mode_out, entry_out, write_out, read_out, erase_prog_out, erase_data_out} = 6'h00;
        addr_out  = 16'h0000;
        wdata_out = 14'h0000;
    end
    // Mode and entry method change only between requests
    task automatic set_mode(input logic m, input logic e);
        @(posedge clk_in);
        #1;
        mode_out  = m;
        entry_out = e;
    endtask
    // Kind: 0 write, 1 read, 2 erase program, 3 erase data
    task automatic req(input int kind, input logic [15:0] a, input logic [13:0] d,
                       output logic [13:0] q, output logic [3:0] st);
        @(posedge clk_in);
        #1;
        addr_out  = a;
        wdata_out = d;
        case (kind)
            0: write_out = 1'b1;
            1: read_out = 1'b1;
            2: erase_prog_out = 1'b1;
            default: erase_data_out = 1'b1;
        endcase
        @(posedge clk_in);
        #1;
        q  = ans_in[13:0];
        st = ans_in[17:14];
        {write_out, read_out, erase_prog_out, erase_data_out} = 4'h0;
        // Released lines show garbage, not the last value
        addr_out  = ~a;
        wdata_out = ~d;
    endtask
endmodule
`default_nettype wire

// [testbench/config_word_decoder_tb.sv]
// Self-checking bench for the configuration word decoder.
// Assumes the programmer model drives the programming port; bench drives self-writes.
`timescale 1ns/1ps
`default_nettype none
module config_word_decoder_tb;
    import config_word_pkg::*;
    localparam logic [13:0] CAL1 = 14'h2d5a; // Arbitrary calibration value
    localparam logic [13:0] CAL2 = 14'h12c3; // Arbitrary calibration value
    logic        clk = 1'b0;
    logic        rst_n;
    logic        mode, lowv, wr, rd, ep, ed, rvalid, refused, perase, derase;
    logic        sw_req, blocked, granted;
    logic [15:0] addr;
    logic [13:0] wdata, rdata, sw_addr, w1, w2, prev, q, lim;
    logic [3:0]  st;
    logic        exp_blk;
    settings_t   settings;
    int          bad_count = 0;
    int          checks_done = 0;
    logic [15:0] ra [5] = '{16'h8007, 16'h8008, 16'h8009, 16'h800a, 16'h8005};
    logic [13:0] re [5] = '{14'h3fff, 14'h3fff, CAL1, CAL2, 14'h0000};
    logic [13:0] sa [5] = '{14'h01ff, 14'h0200, 14'h07ff, 14'h0800, 14'h0fff};
    always #4 clk = ~clk;
    prog_model u_prog (.clk_in(clk), .ans_in({rvalid, refused, perase, derase, rdata}), .mode_out(mode),
        .entry_out(lowv), .addr_out(addr), .write_out(wr), .wdata_out(wdata), .read_out(rd),
        .erase_prog_out(ep), .erase_data_out(ed));
    config_word_decoder #(.CAL_ONE_INIT(CAL1), .CAL_TWO_INIT(CAL2)) u_dut (.ref_clk_in(clk), .rst_n_in(rst_n),
        .prog_mode_in(mode), .lvp_entry_in(lowv), .prog_addr_in(addr), .prog_write_in(wr),
        .prog_wdata_in(wdata), .prog_read_in(rd), .erase_program_in(ep), .erase_data_in(ed),
        .prog_rdata_out(rdata), .prog_rvalid_out(rvalid), .lvp_refused_out(refused),
        .program_erase_out(perase), .data_erase_out(derase), .self_write_req_in(sw_req),
        .self_write_addr_in(sw_addr), .self_write_blocked_out(blocked),
        .self_write_granted_out(granted), .settings_out(settings));
    function automatic settings_t exp_set(input logic [13:0] a, input logic [13:0] b);
        settings_t s;
        s = {a[13], a[12], !a[11], a[10:9], !a[8], !a[7], b[13] | a[6], !a[5], a[4:3], a[2:0],
             b[13], !b[12], 1'b0, b[10], b[9], b[8], 1'b0, b[5:4], b[1:0]};
        return s;
    endfunction
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        stop_test();
    end
    initial begin
        rst_n   = 1'b0;
        sw_req  = 1'b0;
        sw_addr = 14'h0000;
        prev    = 14'h3fff;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1 check("blank settings", settings, exp_set(14'h3fff, 14'h3fff));
        u_prog.set_mode(1'b1, 1'b0);
        for (int k = 0; k < 5; k++) begin
            u_prog.req(1, ra[k], 14'h0000, q, st);
            check("read word", q, re[k]);
            check("read valid", st[3], 1'b1);
        end
        $display("test reads done");
        for (int i = 0; i < 8; i++) begin
            w1 = {i[2:0], i[2:0], i[2:0], i[1:0], i[2:0]};
            w2 = {i[1:0], i[2:0], i[2:0], i[2:0], i[2:0]};
            u_prog.req(2, 16'h0000, 14'h0000, q, st);
            check("erase strobes", st[1:0], {1'b1, !prev[8]});
            u_prog.req(0, CFG_ONE_ADDR, w1, q, st);
            u_prog.req(0, CFG_TWO_ADDR, w2, q, st);
            u_prog.req(0, CAL_ONE_ADDR, 14'h0000, q, st);
            u_prog.req(1, CFG_ONE_ADDR, 14'h0000, q, st);
            check("word one", q, w1);
            u_prog.req(1, CFG_TWO_ADDR, 14'h0000, q, st);
            check("word two", q, w2 | TWO_ONES_MAIN);
            u_prog.req(1, CAL_ONE_ADDR, 14'h0000, q, st);
            check("calibration", q, CAL1);
            u_prog.set_mode(1'b0, 1'b0);
            repeat (2) @(posedge clk);
            #1 check("settings", settings, exp_set(w1, w2));
            lim = (w2[1:0] == 2'b10) ? 14'h01ff : (w2[1:0] == 2'b01) ? 14'h07ff : 14'h0fff;
            for (int k = 0; k < 5; k++) begin
                sw_req  = 1'b1;
                sw_addr = sa[k];
                exp_blk = (w2[1:0] != 2'b11) && (sa[k] <= lim);
                @(posedge clk);
                #1 check("self write", {blocked, granted}, {exp_blk, !exp_blk});
                sw_req  = 1'b0;
                sw_addr = ~sa[k];
                @(posedge clk);
                #1;
            end
            prev = w1;
            u_prog.set_mode(1'b1, 1'b0);
        end
        $display("test decode done");
        u_prog.req(3, 16'h0000, 14'h0000, q, st);
        check("data erase", st[1:0], 2'b01);
        u_prog.set_mode(1'b1, 1'b1);
        u_prog.req(2, 16'h0000, 14'h0000, q, st);
        u_prog.req(0, CFG_TWO_ADDR, 14'h1fff, q, st);
        check("refusal strobe", st[2], 1'b1);
        u_prog.req(1, CFG_TWO_ADDR, 14'h0000, q, st);
        check("low volt bit kept", q, 14'h3fff);
        u_prog.set_mode(1'b1, 1'b0);
        u_prog.req(0, CFG_TWO_ADDR, 14'h1fff, q, st);
        check("no refusal", st[2], 1'b0);
        u_prog.set_mode(1'b1, 1'b1);
        u_prog.req(2, 16'h0000, 14'h0000, q, st);
        u_prog.req(1, CFG_TWO_ADDR, 14'h0000, q, st);
        check("low volt bit after erase", q, 14'h1fff);
        u_prog.set_mode(1'b0, 1'b0);
        u_prog.req(1, CFG_ONE_ADDR, 14'h0000, q, st);
        check("idle read", st[3], 1'b0);
        $display("test refusals done");
        stop_test();
    end
endmodule
`default_nettype wire
